// [hw/cgl_consts.vh]
`ifndef CGL_CONSTS_VH
`define CGL_CONSTS_VH

// ==================================================
// register indices (byte address is index times four)
`define CGL_IDX_UNIT      6'h00
`define CGL_IDX_SEQ       6'h01
`define CGL_IDX_LUT0_CTLA 6'h05
`define CGL_IDX_LUT0_SELL 6'h06
`define CGL_IDX_LUT0_SELH 6'h07
`define CGL_IDX_LUT0_TRU  6'h08
`define CGL_IDX_LUT1_CTLA 6'h09
`define CGL_IDX_LUT1_SELL 6'h0A
`define CGL_IDX_LUT1_SELH 6'h0B
`define CGL_IDX_LUT1_TRU  6'h0C
`define CGL_RESET_VAL     8'h00

// ==================================================
// field positions
`define CGL_UNIT_EN       0
`define CGL_UNIT_STBY_RUN 6
`define CGL_LUT_EN        0
`define CGL_LUT_PIN_OE    3
`define CGL_LUT_FILT_LO   4
`define CGL_LUT_CLK_SEL   6
`define CGL_LUT_EDGE      7
`define CGL_UNIT_MASK     8'h41
`define CGL_SEQ_MASK      8'h0F
`define CGL_LUTA_MASK     8'hF9

// ==================================================
// encodings
`define CGL_SRC_MASK      4'h0
`define CGL_SRC_FEEDBACK  4'h1
`define CGL_SRC_LINK      4'h2
`define CGL_SRC_EV_ZERO   4'h3
`define CGL_SRC_EV_ONE    4'h4
`define CGL_SRC_PIN       4'h5
`define CGL_SRC_PERIPH    4'h6
`define CGL_NUM_PERIPH    6
`define CGL_SEQ_OFF       4'h0
`define CGL_SEQ_DFLOP     4'h1
`define CGL_SEQ_JK        4'h2
`define CGL_SEQ_DLAT      4'h3
`define CGL_SEQ_RS        4'h4
`define CGL_FILT_NONE     2'h0
`define CGL_FILT_SYNC     2'h1
`define CGL_FILT_GLITCH   2'h2

`endif

// [hw/cgl_table_stage.v]
`timescale 1ns/1ns
`default_nettype none
`include "cgl_consts.vh"

// output filter and edge detector of one table
module cgl_table_stage (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // control
  input  wire       en,
  input  wire       tick,
  input  wire [1:0] filt_sel,
  input  wire       edge_en,
  // data
  input  wire       lut_val,
  output reg        stage_out
);

  reg [3:0] chain_q;
  reg       glitch_q;
  reg       edge_prev_q;
  reg       edge_pulse_q;
  reg       filt_val;

  always @* begin
    if (filt_sel == `CGL_FILT_SYNC) begin
      filt_val = chain_q[1];
    end else if (filt_sel == `CGL_FILT_GLITCH) begin
      filt_val = glitch_q;
    end else begin
      filt_val = lut_val;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_q      <= 4'h0;
      glitch_q     <= 1'b0;
      edge_prev_q  <= 1'b0;
      edge_pulse_q <= 1'b0;
    end else if (!en) begin
      chain_q      <= 4'h0;
      glitch_q     <= 1'b0;
      edge_prev_q  <= 1'b0;
      edge_pulse_q <= 1'b0;
    end else if (tick) begin
      chain_q <= {chain_q[2:0], lut_val};
      // glitch filter only moves once three stages agree
      if (chain_q[3:1] == 3'h7) begin
        glitch_q <= 1'b1;
      end else if (chain_q[3:1] == 3'h0) begin
        glitch_q <= 1'b0;
      end
      edge_prev_q  <= filt_val;
      edge_pulse_q <= edge_en & filt_val & ~edge_prev_q;
    end
  end

  always @* begin
    if (edge_en) begin
      stage_out = edge_pulse_q;
    end else begin
      stage_out = filt_val;
    end
  end

endmodule
`default_nettype wire

// [hw/cgl_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "cgl_consts.vh"

module cgl_top (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // table input pins: bit 3n+y is table n input y
  input  wire [5:0]  table_in_pin,
  // event lines from the routing network
  input  wire        event_line_zero,
  input  wire        event_line_one,
  // peripheral sources for codes 6 to 11
  input  wire [5:0]  periph_src,
  // sleep state from the power controller
  input  wire        standby_sleep,
  input  wire        idle_sleep,
  // table outputs
  output reg  [1:0]  table_output_signal,
  output reg  [1:0]  pin_output_enable,
  output reg  [1:0]  table_out_event
);

  // ==================================================
  // registers
  reg [7:0] unit_q;
  reg [7:0] seq_q;
  reg [7:0] ctla_q [0:1];
  reg [7:0] sell_q [0:1];
  reg [7:0] selh_q [0:1];
  reg [7:0] truth_q [0:1];

  // ==================================================
  // input synchronisers: stage one feeds stage two only
  reg [13:0] sync1_q;
  reg [13:0] sync2_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
    end else begin
      sync1_q <= {periph_src, event_line_one, event_line_zero, table_in_pin};
      sync2_q <= sync1_q;
    end
  end

  wire [5:0] pin_s    = sync2_q[5:0];
  wire       ev0_s    = sync2_q[6];
  wire       ev1_s    = sync2_q[7];
  wire [5:0] periph_s = sync2_q[13:8];

  // ==================================================
  // apb slave: zero wait states, unmapped index answers an error
  reg        mapped;
  reg  [7:0] rd_val;
  wire       acc  = psel & penable;
  wire       wr   = acc & pwrite & mapped;
  wire [5:0] widx = paddr[7:2];
  wire [7:0] wb   = pwdata[7:0];

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always @* begin
    mapped = 1'b1;
    rd_val = 8'h00;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (widx == `CGL_IDX_UNIT) begin
      rd_val = unit_q;
    end else if (widx == `CGL_IDX_SEQ) begin
      rd_val = seq_q;
    end else if (widx == `CGL_IDX_LUT0_CTLA) begin
      rd_val = ctla_q[0];
    end else if (widx == `CGL_IDX_LUT0_SELL) begin
      rd_val = sell_q[0];
    end else if (widx == `CGL_IDX_LUT0_SELH) begin
      rd_val = selh_q[0];
    end else if (widx == `CGL_IDX_LUT0_TRU) begin
      rd_val = truth_q[0];
    end else if (widx == `CGL_IDX_LUT1_CTLA) begin
      rd_val = ctla_q[1];
    end else if (widx == `CGL_IDX_LUT1_SELL) begin
      rd_val = sell_q[1];
    end else if (widx == `CGL_IDX_LUT1_SELH) begin
      rd_val = selh_q[1];
    end else if (widx == `CGL_IDX_LUT1_TRU) begin
      rd_val = truth_q[1];
    end else begin
      mapped = 1'b0;
    end
  end

  // read data is latched in the setup cycle so it stands for the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  // ==================================================
  // register writes; table settings are locked while that table runs
  wire lut0_off = ~ctla_q[0][`CGL_LUT_EN];
  wire lut1_off = ~ctla_q[1][`CGL_LUT_EN];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_q     <= `CGL_RESET_VAL;
      seq_q      <= `CGL_RESET_VAL;
      ctla_q[0]  <= `CGL_RESET_VAL;
      ctla_q[1]  <= `CGL_RESET_VAL;
      sell_q[0]  <= `CGL_RESET_VAL;
      sell_q[1]  <= `CGL_RESET_VAL;
      selh_q[0]  <= `CGL_RESET_VAL;
      selh_q[1]  <= `CGL_RESET_VAL;
      truth_q[0] <= `CGL_RESET_VAL;
      truth_q[1] <= `CGL_RESET_VAL;
    end else if (wr) begin
      if (widx == `CGL_IDX_UNIT) begin
        unit_q <= wb & `CGL_UNIT_MASK;
      end else if (widx == `CGL_IDX_SEQ && lut0_off) begin
        seq_q <= wb & `CGL_SEQ_MASK;
      end else if (widx == `CGL_IDX_LUT0_CTLA) begin
        if (lut0_off) begin
          ctla_q[0] <= wb & `CGL_LUTA_MASK;
        end else begin
          ctla_q[0][`CGL_LUT_EN] <= wb[`CGL_LUT_EN];
        end
      end else if (widx == `CGL_IDX_LUT0_SELL && lut0_off) begin
        sell_q[0] <= wb;
      end else if (widx == `CGL_IDX_LUT0_SELH && lut0_off) begin
        selh_q[0] <= {4'h0, wb[3:0]};
      end else if (widx == `CGL_IDX_LUT0_TRU && lut0_off) begin
        truth_q[0] <= wb;
      end else if (widx == `CGL_IDX_LUT1_CTLA) begin
        if (lut1_off) begin
          ctla_q[1] <= wb & `CGL_LUTA_MASK;
        end else begin
          ctla_q[1][`CGL_LUT_EN] <= wb[`CGL_LUT_EN];
        end
      end else if (widx == `CGL_IDX_LUT1_SELL && lut1_off) begin
        sell_q[1] <= wb;
      end else if (widx == `CGL_IDX_LUT1_SELH && lut1_off) begin
        selh_q[1] <= {4'h0, wb[3:0]};
      end else if (widx == `CGL_IDX_LUT1_TRU && lut1_off) begin
        truth_q[1] <= wb;
      end
    end
  end

  // ==================================================
  // input source selection
  function pick_src;
    input [3:0] code;
    input       fb;
    input       link;
    input       pin;
    input       ev0;
    input       ev1;
    input [5:0] per;
    reg   [3:0] pidx;
    begin
      pidx = code - `CGL_SRC_PERIPH;
      if (code == `CGL_SRC_FEEDBACK) begin
        pick_src = fb;
      end else if (code == `CGL_SRC_LINK) begin
        pick_src = link;
      end else if (code == `CGL_SRC_EV_ZERO) begin
        pick_src = ev0;
      end else if (code == `CGL_SRC_EV_ONE) begin
        pick_src = ev1;
      end else if (code == `CGL_SRC_PIN) begin
        pick_src = pin;
      end else if (code >= `CGL_SRC_PERIPH && pidx < `CGL_NUM_PERIPH) begin
        pick_src = per[pidx[2:0]];
      end else begin
        pick_src = 1'b0;
      end
    end
  endfunction

  // ==================================================
  // per table datapath
  reg        seq_out_q;
  reg  [1:0] in2_prev_q;
  wire [1:0] stage_out;
  wire [1:0] run;
  wire [1:0] tick;
  wire [1:0] lut_val;
  wire [1:0] in2_raw;
  wire       clk_stop = standby_sleep & ~unit_q[`CGL_UNIT_STBY_RUN];

  genvar n;
  generate
    for (n = 0; n < 2; n = n + 1) begin : g_tbl
      wire       link = (n == 0) ? stage_out[1] : 1'b0;
      wire       src0;
      wire       src1;
      wire [2:0] idx;
      assign src0 = pick_src(sell_q[n][3:0], seq_out_q, link, pin_s[3*n],
                             ev0_s, ev1_s, periph_s);
      assign src1 = pick_src(sell_q[n][7:4], seq_out_q, link, pin_s[3*n+1],
                             ev0_s, ev1_s, periph_s);
      assign in2_raw[n] = pick_src(selh_q[n][3:0], seq_out_q, link, pin_s[3*n+2],
                                   ev0_s, ev1_s, periph_s);
      // with the clock select bit set, line 2 is the clock, so it drops out of the index
      assign idx = {in2_raw[n] & ~ctla_q[n][`CGL_LUT_CLK_SEL], src1, src0};
      // decoder runs in any sleep state
      assign lut_val[n] = run[n] & truth_q[n][idx];
      assign run[n] = unit_q[`CGL_UNIT_EN] & ctla_q[n][`CGL_LUT_EN];
      assign tick[n] = ~clk_stop & (ctla_q[n][`CGL_LUT_CLK_SEL] ?
                       (in2_raw[n] & ~in2_prev_q[n]) : 1'b1);

      cgl_table_stage u_stage (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (run[n]),
        .tick      (tick[n]),
        .filt_sel  (ctla_q[n][5:4]),
        .edge_en   (ctla_q[n][`CGL_LUT_EDGE]),
        .lut_val   (lut_val[n]),
        .stage_out (stage_out[n])
      );
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in2_prev_q <= 2'b00;
    end else begin
      in2_prev_q <= in2_raw;
    end
  end

  // ==================================================
  // sequential element, paced by the even table's clock
  wire [3:0] seq_sel  = seq_q[3:0];
  wire       seq_on   = (seq_sel >= `CGL_SEQ_DFLOP) && (seq_sel <= `CGL_SEQ_RS);
  wire       even_in  = stage_out[0];
  wire       odd_in   = stage_out[1];
  reg        seq_out_d;

  always @* begin
    seq_out_d = seq_out_q;
    case (seq_sel)
      `CGL_SEQ_DFLOP: begin
        if (odd_in) begin
          seq_out_d = even_in;
        end
      end
      `CGL_SEQ_JK: begin
        case ({even_in, odd_in})
          2'b01: seq_out_d = 1'b0;
          2'b10: seq_out_d = 1'b1;
          2'b11: seq_out_d = ~seq_out_q;
          default: seq_out_d = seq_out_q;
        endcase
      end
      `CGL_SEQ_DLAT: begin
        if (odd_in) begin
          seq_out_d = even_in;
        end
      end
      `CGL_SEQ_RS: begin
        // both high is forbidden; reset is given the upper hand here
        if (odd_in) begin
          seq_out_d = 1'b0;
        end else if (even_in) begin
          seq_out_d = 1'b1;
        end
      end
      default: seq_out_d = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_out_q <= 1'b0;
    end else if (!run[0] || !seq_on) begin
      seq_out_q <= 1'b0;
    end else if (tick[0]) begin
      seq_out_q <= seq_out_d;
    end
  end

  // ==================================================
  // outputs; clocked paths go quiet in standby without the run bit
  reg [1:0] final_val;
  reg [1:0] clocked;
  integer   k;
  integer   j;

  always @* begin
    final_val = 2'b00;
    clocked   = 2'b00;
    for (k = 0; k < 2; k = k + 1) begin
      clocked[k] = (ctla_q[k][5:4] != `CGL_FILT_NONE) |
                   ctla_q[k][`CGL_LUT_EDGE] | seq_on;
      final_val[k] = stage_out[k];
    end
    if (seq_on) begin
      final_val[0] = seq_out_q;
    end
    for (k = 0; k < 2; k = k + 1) begin
      if (clk_stop && clocked[k]) begin
        final_val[k] = 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_output_signal <= 2'b00;
      pin_output_enable   <= 2'b00;
      table_out_event     <= 2'b00;
    end else begin
      table_out_event <= final_val & run;
      for (j = 0; j < 2; j = j + 1) begin
        pin_output_enable[j]   <= run[j] & ctla_q[j][`CGL_LUT_PIN_OE];
        table_output_signal[j] <= run[j] & ctla_q[j][`CGL_LUT_PIN_OE] & final_val[j];
      end
    end
  end

  // idle sleep changes nothing here
  wire unused_idle = idle_sleep;

endmodule
`default_nettype wire

// [verification/cgl_far_side.sv]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// pins, event network and peripherals
module cgl_far_side (
  // clock
  input  wire logic       pclk,
  // levels asked for by the bench
  input  wire logic [5:0] want_pin,
  input  wire logic [1:0] want_ev,
  input  wire logic [5:0] want_per,
  input  wire logic       routed,
  // towards the block
  output var  logic [5:0] table_in_pin,
  output var  logic       event_line_zero,
  output var  logic       event_line_one,
  output var  logic [5:0] periph_src
);
  initial {table_in_pin, event_line_zero, event_line_one, periph_src} = 14'h0000;
  // sources move just after an edge, like on-chip drivers
  always @(posedge pclk) begin
    table_in_pin <= want_pin;
    periph_src <= want_per;
    // unrouted lines idle low, so routing comes first
    event_line_zero <= routed & want_ev[0];
    event_line_one <= routed & want_ev[1];
  end
endmodule
`default_nettype wire

// [verification/cgl_top_props.sv]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// bus and output relations
module cgl_top_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // outputs
  input wire logic [1:0]  table_output_signal,
  input wire logic [1:0]  pin_output_enable,
  input wire logic [1:0]  table_out_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // indices 2..4 and above 12 hold nothing
  wire logic hole = (paddr[7:2] > 6'h0c) || (paddr[7:2] > 6'h01 && paddr[7:2] < 6'h05);
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_err_cause;
    s_access |-> pslverr == (hole || paddr[1:0] != 2'b00);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error flag wrong");
  property p_unmapped;
    (s_rd_setup ##0 hole) |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_gate;
    (table_output_signal & ~pin_output_enable) == 2'b00;
  endproperty
  a_gate: assert property (p_gate) else $error("pin driven while off");
  property p_mirror;
    ((table_output_signal ^ table_out_event) & pin_output_enable) == 2'b00;
  endproperty
  a_mirror: assert property (p_mirror) else $error("event and pin differ");
  property p_clr1;
    $fell(pin_output_enable[1]) |-> !table_out_event[1] [*2];
  endproperty
  a_clr1: assert property (p_clr1) else $error("table 1 not cleared");
  property p_clr0;
    $fell(pin_output_enable[0]) |-> !table_out_event[0] [*2];
  endproperty
  a_clr0: assert property (p_clr0) else $error("table 0 not cleared");
endmodule

bind cgl_top cgl_top_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .table_output_signal(table_output_signal), .pin_output_enable(pin_output_enable),
  .table_out_event(table_out_event)
);
`default_nettype wire

// [verification/cgl_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module cgl_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, ev0, ev1, routed = 1'b0;
  logic        standby_sleep = 1'b0, idle_sleep = 1'b0;
  logic [5:0]  pin, per, want_pin = 6'h00, want_per = 6'h00;
  logic [1:0]  want_ev = 2'b00, tos, poe, toe;
  int          n_errors = 0, tests_run = 0;

  cgl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .table_in_pin(pin), .event_line_zero(ev0), .event_line_one(ev1),
    .periph_src(per), .standby_sleep(standby_sleep), .idle_sleep(idle_sleep),
    .table_output_signal(tos), .pin_output_enable(poe), .table_out_event(toe));
  cgl_far_side u_far (.pclk(pclk), .want_pin(want_pin), .want_ev(want_ev),
    .want_per(want_per), .routed(routed), .table_in_pin(pin), .event_line_zero(ev0),
    .event_line_one(ev1), .periph_src(per));

  always #10 pclk = ~pclk;

  // ==================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, i, d, q, e);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, i, 8'h00, q, e);
    check(q, {24'h00_0000, x});
    check(e, xe);
  endtask
  // table disabled first: its setup is locked while it runs
  task automatic cfg(input logic t, input logic [7:0] lo, input logic [7:0] hi,
                     input logic [7:0] tt, input logic [7:0] ca);
    logic [5:0] b;
    b = t ? 6'h09 : 6'h05;
    wr(b, 8'h00);
    wr(b + 6'h01, lo);
    wr(b + 6'h02, hi);
    wr(b + 6'h03, tt);
    wr(b, ca);
  endtask

  // ==================================================
  // scenarios
  task automatic s_regs;
    logic [5:0] ix [0:9] = '{6'h00, 6'h01, 6'h06, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0c,
                             6'h05, 6'h09};
    logic [7:0] mk [0:9] = '{8'h41, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff,
                             8'hf9, 8'hf9};
    for (int i = 0; i < 10; i++) begin
      rd(ix[i], 8'h00, 1'b0);
      wr(ix[i], 8'hff);
      rd(ix[i], mk[i], 1'b0);
    end
    rd(6'h03, 8'h00, 1'b1);
    wr(6'h08, 8'h00);
    rd(6'h08, 8'hff, 1'b0);
    wr(6'h05, 8'h00);
    wr(6'h09, 8'h00);
    for (int i = 0; i < 10; i++) wr(ix[i], 8'h00);
  endtask
  task automatic s_truth;
    logic [7:0] t0 = 8'hb4, t1 = 8'h6c;
    routed <= 1'b1;
    wr(6'h00, 8'h01);
    cfg(1'b0, 8'h55, 8'h05, t0, 8'h09);
    cfg(1'b1, 8'h43, 8'h06, t1, 8'h09);
    for (int v = 0; v < 8; v++) begin
      want_pin <= {3'b000, v[2:0]};
      want_ev <= v[1:0];
      want_per <= {5'h00, v[2]};
      tick(5);
      check(tos[0], t0[v]);
      check(toe[1], t1[v]);
    end
  endtask
  task automatic s_link;
    cfg(1'b1, 8'h05, 8'h00, 8'haa, 8'h09);
    cfg(1'b0, 8'h02, 8'h00, 8'haa, 8'h09);
    for (int v = 1; v >= 0; v--) begin
      want_pin <= {2'b00, v[0], 3'b000};
      tick(6);
      check(tos[0], v[0]);
    end
  endtask
  task automatic meas(input logic [7:0] ca, output int d);
    cfg(1'b1, 8'h05, 8'h00, 8'haa, ca);
    want_pin <= 6'h00;
    tick(10);
    want_pin <= 6'h08;
    d = 0;
    while (tos[1] !== 1'b1 && d < 20) begin
      @(posedge pclk);
      d++;
    end
  endtask
  task automatic edge_cnt(input logic [7:0] tt, input logic [5:0] p0);
    int c;
    c = 0;
    cfg(1'b1, 8'h05, 8'h00, tt, 8'h99);
    want_pin <= p0;
    tick(10);
    want_pin <= p0 ^ 6'h08;
    repeat (15) begin
      @(posedge pclk);
      c += tos[1];
    end
    check(c, 1);
  endtask
  task automatic s_filter;
    int b, d;
    meas(8'h09, b);
    for (int f = 1; f < 3; f++) begin
      meas(8'h09 | 8'(f << 4), d);
      check(d - b >= 2 && d - b <= 5, 1'b1);
    end
    edge_cnt(8'haa, 6'h00);
    edge_cnt(8'h55, 6'h08);
  endtask
  task automatic s_clock_source_bit;
    wr(6'h00, 8'h00);
    cfg(1'b1, 8'h05, 8'h05, 8'h0a, 8'h59);
    wr(6'h00, 8'h01);
    want_pin <= 6'h08;
    tick(10);
    check(tos[1], 1'b0);
    repeat (4) begin
      want_pin <= 6'h28;
      tick(3);
      want_pin <= 6'h08;
      tick(3);
    end
    check(tos[1], 1'b1);
    wr(6'h00, 8'h00);
    wr(6'h09, 8'h00);
    wr(6'h00, 8'h01);
  endtask
  task automatic s_sleep;
    cfg(1'b0, 8'h05, 8'h00, 8'haa, 8'h09);
    cfg(1'b1, 8'h05, 8'h00, 8'haa, 8'h19);
    want_pin <= 6'h09;
    tick(10);
    idle_sleep <= 1'b1;
    tick(4);
    check(tos, 2'b11);
    idle_sleep <= 1'b0;
    standby_sleep <= 1'b1;
    tick(4);
    check(tos, 2'b01);
    check(poe, 2'b11);
    standby_sleep <= 1'b0;
    wr(6'h00, 8'h41);
    standby_sleep <= 1'b1;
    tick(4);
    check(tos, 2'b11);
    standby_sleep <= 1'b0;
  endtask
  // nibble per step: table0 level, table1 level, one-cycle pulse, expected
  task automatic s_seq;
    logic [15:0] st [0:3] = '{16'hd14d, 16'h91ef, 16'hd148, 16'h9149};
    logic [3:0] s;
    cfg(1'b1, 8'h05, 8'h00, 8'haa, 8'h09);
    cfg(1'b0, 8'h05, 8'h00, 8'haa, 8'h09);
    for (int m = 0; m < 4; m++) begin
      want_pin <= 6'h00;
      wr(6'h05, 8'h00);
      wr(6'h01, 8'(m + 1));
      wr(6'h05, 8'h09);
      for (int k = 0; k < 4; k++) begin
        s = st[m][15 - 4 * k -: 4];
        want_pin <= {2'b00, s[2], 2'b00, s[3]};
        if (s[1]) begin
          tick(1);
          want_pin <= 6'h00;
        end
        tick(6);
        check(tos[0], s[0]);
      end
      want_pin <= 6'h00;
      wr(6'h05, 8'h00);
      wr(6'h05, 8'h09);
      tick(6);
      check(tos[0], 1'b0);
    end
    wr(6'h05, 8'h00);
    wr(6'h01, 8'h00);
  endtask

  // ==================================================
  // run
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_truth();
    s_link();
    s_filter();
    s_clock_source_bit();
    s_sleep();
    s_seq();
    print_verdict();
  end
endmodule
`default_nettype wire
